// >>> dsfh_scrub.sv
// DRAM ECC init and scrub engine with fixed hole control
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module dsfh_scrub (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Memory size in lines, last line index
	input wire logic [dsfh_pkg::DSFH_LINE_AW-1:0] mem_last_line,
	// Memory request to DRAM engine
	output logic mem_req,
	output logic mem_we,
	output logic [dsfh_pkg::DSFH_LINE_AW-1:0] mem_line,
	input wire logic mem_ack,
	// Read response of a scrub read
	input wire logic mem_rsp,
	input wire logic mem_corr,
	input wire logic mem_uncorr,
	// Host access steering
	input wire logic [dsfh_pkg::DSFH_HADDR_W-1:0] host_addr,
	input wire logic host_valid,
	output logic host_to_hub,
	output logic host_to_dram,
	// Interrupt
	output logic irq
);
	import dsfh_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic en;
		logic mode;
		logic done;
		logic hole_en;
		logic [DSFH_IRQ_W-1:0] stat;
		logic [DSFH_IRQ_W-1:0] mask;
		dsfh_state_t st;
		logic [DSFH_LINE_AW-1:0] line;
		logic [DSFH_TMR_W-1:0] tmr;
		logic [15:0] rdata;
	} dsfh_regs_t;

	dsfh_regs_t cur_ff;
	dsfh_regs_t nxt_ff;
	logic [15:0] cfg_view;
	logic [7:0] hole_view;
	logic last;

	assign cfg_view = {12'h000, cur_ff.done, cur_ff.mode, 1'b0, cur_ff.en};
	assign hole_view = {cur_ff.hole_en, 7'h00};
	assign last = (cur_ff.line == mem_last_line);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.rdata = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				DSFH_ADDR_SCRUB_CFG: nxt_ff.rdata = cfg_view;
				DSFH_ADDR_HOLE_CTL: nxt_ff.rdata = {8'h00, hole_view};
				DSFH_ADDR_IRQ_STAT: begin
					nxt_ff.rdata = {13'h0000, cur_ff.stat};
					nxt_ff.stat = '0;
				end
				DSFH_ADDR_IRQ_MASK: nxt_ff.rdata = {13'h0000, cur_ff.mask};
				default: nxt_ff.rdata = 16'h0000;
			endcase
		end
		if (reg_wr) begin
			case (reg_addr)
				DSFH_ADDR_SCRUB_CFG: begin
					nxt_ff.en = reg_wdata[DSFH_CFG_EN_BIT]; // see RL4
					nxt_ff.mode = reg_wdata[DSFH_CFG_MODE_BIT]; // see RL3
				end
				DSFH_ADDR_HOLE_CTL: nxt_ff.hole_en = reg_wdata[DSFH_HOLE_EN_BIT]; // see RL7
				DSFH_ADDR_IRQ_MASK: nxt_ff.mask = reg_wdata[DSFH_IRQ_W-1:0];
				default: ;
			endcase
		end
		// Engine; disable at any time drops back to idle after the open request
		case (cur_ff.st)
			DSFH_IDLE: begin
				if (cur_ff.en) begin // see RL4
					if (!cur_ff.mode && !cur_ff.done) begin
						nxt_ff.line = '0;
						nxt_ff.st = DSFH_ISSUE; // see RL1
					end else if (cur_ff.mode) begin
						nxt_ff.tmr = DSFH_TMR_W'(DSFH_SCRUB_CYC - 1);
						nxt_ff.st = DSFH_WAIT; // see RL2
					end
				end
			end
			DSFH_WAIT: begin
				if (!cur_ff.en || !cur_ff.mode)
					nxt_ff.st = DSFH_IDLE;
				else if (cur_ff.tmr == '0) begin
					nxt_ff.tmr = DSFH_TMR_W'(DSFH_SCRUB_CYC - 1);
					nxt_ff.st = DSFH_ISSUE; // see RL2
				end else
					nxt_ff.tmr = cur_ff.tmr - 1'b1;
			end
			DSFH_ISSUE: begin
				if (cur_ff.tmr != '0)
					nxt_ff.tmr = cur_ff.tmr - 1'b1;
				if (mem_ack) begin
					if (cur_ff.mode)
						nxt_ff.st = DSFH_RESP; // see RL2
					else if (last) begin
						nxt_ff.done = 1'b1; // see RL5
						nxt_ff.stat[DSFH_IRQ_INIT_DONE] = 1'b1;
						nxt_ff.st = DSFH_IDLE;
					end else begin
						// Back to back: next line issued without a gap
						nxt_ff.line = cur_ff.line + 1'b1; // see RL1
						if (!cur_ff.en || cur_ff.mode)
							nxt_ff.st = DSFH_IDLE;
					end
				end
			end
			DSFH_RESP: begin
				if (cur_ff.tmr != '0)
					nxt_ff.tmr = cur_ff.tmr - 1'b1;
				if (mem_rsp) begin
					if (mem_corr)
						nxt_ff.stat[DSFH_IRQ_CORR] = 1'b1;
					if (mem_uncorr)
						nxt_ff.stat[DSFH_IRQ_UNCORR] = 1'b1;
					nxt_ff.line = last ? '0 : cur_ff.line + 1'b1; // see RL2
					nxt_ff.st = (cur_ff.en && cur_ff.mode) ? DSFH_WAIT : DSFH_IDLE;
				end
			end
			default: nxt_ff.st = DSFH_IDLE;
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_ff.en <= DSFH_CFG_RESET[DSFH_CFG_EN_BIT]; // see RL9
			cur_ff.mode <= DSFH_CFG_RESET[DSFH_CFG_MODE_BIT];
			cur_ff.done <= DSFH_CFG_RESET[DSFH_CFG_DONE_BIT];
			cur_ff.hole_en <= DSFH_HOLE_RESET[DSFH_HOLE_EN_BIT];
			cur_ff.stat <= '0;
			cur_ff.mask <= '0;
			cur_ff.st <= DSFH_IDLE;
			cur_ff.line <= '0;
			cur_ff.tmr <= '0;
			cur_ff.rdata <= 16'h0000;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Scrub correction write-back is left to the DRAM engine on the read
	assign mem_req = (cur_ff.st == DSFH_ISSUE);
	assign mem_we = !cur_ff.mode;
	assign mem_line = cur_ff.line;
	assign reg_rdata = cur_ff.rdata;
	assign irq = |(cur_ff.stat & cur_ff.mask);

	dsfh_hole_dec u_hole (
		.hole_en(cur_ff.hole_en),
		.host_addr(host_addr),
		.host_valid(host_valid),
		.to_hub(host_to_hub),
		.to_dram(host_to_dram)
	);

endmodule // dsfh_scrub

// >>> dsfh_pkg.sv
// Package of constants and types for the DRAM ECC scrub and fixed hole block
//
// Behaviour
// RL1: Init mode writes every line back to back
// RL2: Scrub mode reads, corrects one line per interval
// RL3: Config bit 2 selects init or scrub
// RL4: Config bit 0 enables the engine
// RL5: Read-only bit 3 flags init complete
// RL6: Software inits, polls done, then scrubs or disables
// RL7: Hole enable routes 15-16 MB to hub port
// RL8: Hidden DRAM is not relocated, only unreachable
// RL9: Both config registers reset to zero
package dsfh_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] DSFH_ADDR_SCRUB_CFG = 8'h52;
	localparam logic [7:0] DSFH_ADDR_HOLE_CTL = 8'h58;
	localparam logic [7:0] DSFH_ADDR_IRQ_STAT = 8'h70;
	localparam logic [7:0] DSFH_ADDR_IRQ_MASK = 8'h71;

	localparam int DSFH_CFG_EN_BIT = 0;
	localparam int DSFH_CFG_MODE_BIT = 2;
	localparam int DSFH_CFG_DONE_BIT = 3;
	localparam int DSFH_HOLE_EN_BIT = 7;

	localparam logic [15:0] DSFH_CFG_RESET = 16'h0000;
	localparam logic [7:0] DSFH_HOLE_RESET = 8'h00;

	// Interrupt status bits
	localparam int DSFH_IRQ_INIT_DONE = 0;
	localparam int DSFH_IRQ_CORR = 1;
	localparam int DSFH_IRQ_UNCORR = 2;
	localparam int DSFH_IRQ_W = 3;

	// ----------------------------------------
	// Address space and timing
	// ----------------------------------------
	localparam int DSFH_LINE_AW = 28;
	localparam int DSFH_HADDR_W = 34;
	localparam logic [33:0] DSFH_HOLE_LO = 34'h00F00000;
	localparam logic [33:0] DSFH_HOLE_HI = 34'h01000000;
	localparam int DSFH_CLK_MHZ = 100;
	localparam int DSFH_SCRUB_CLOCKS = 32000;
	localparam int DSFH_SCRUB_CYC = DSFH_SCRUB_CLOCKS;
	localparam int DSFH_TMR_W = 15;

	typedef enum logic [1:0] {DSFH_IDLE, DSFH_WAIT, DSFH_ISSUE, DSFH_RESP} dsfh_state_t;

endpackage

// >>> dsfh_hole_dec.sv
// Fixed hole decoder steering host accesses
`timescale 1ns/1ps
module dsfh_hole_dec (
	// Control
	input wire logic hole_en,
	// Host access
	input wire logic [dsfh_pkg::DSFH_HADDR_W-1:0] host_addr,
	input wire logic host_valid,
	// Steering
	output logic to_hub,
	output logic to_dram
);
	import dsfh_pkg::*;

	logic in_hole;

	// DRAM behind the hole is simply not reached; no remapping of addresses
	assign in_hole = (host_addr >= DSFH_HOLE_LO) && (host_addr < DSFH_HOLE_HI); // see RL8
	assign to_hub = host_valid && hole_en && in_hole; // see RL7
	assign to_dram = host_valid && !(hole_en && in_hole); // see RL7

endmodule // dsfh_hole_dec

// >>> dsfh_scrub_checker.sv
// Port assertions of the scrub and hole block
`timescale 1ns/1ps
module dsfh_scrub_checker (
	// Clock, reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Registers
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// Memory
	input wire logic [dsfh_pkg::DSFH_LINE_AW-1:0] mem_last_line,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [dsfh_pkg::DSFH_LINE_AW-1:0] mem_line,
	input wire logic mem_ack,
	// Host
	input wire logic [dsfh_pkg::DSFH_HADDR_W-1:0] host_addr,
	input wire logic host_valid,
	input wire logic host_to_hub,
	input wire logic host_to_dram
);
	import dsfh_pkg::*;
	logic in_h;
	logic ack;
	assign in_h = host_valid && host_addr >= DSFH_HOLE_LO && host_addr < DSFH_HOLE_HI;
	assign ack = mem_req && mem_ack;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_hub_range: assert property (host_to_hub |-> in_h)
		else $error("hub outside hole");
	a_outside_dram: assert property (host_valid && !in_h |-> host_to_dram)
		else $error("dram not chosen");
	a_one_target: assert property (!(host_to_hub && host_to_dram))
		else $error("two targets");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("stray read data");
	a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_line))
		else $error("request not held");
	a_init_step: assert property (ack && mem_we && mem_line != mem_last_line |=>
		mem_req && mem_line == $past(mem_line) + 1'b1)
		else $error("init not back to back");
	a_init_last: assert property (ack && mem_we && mem_line == mem_last_line |=> !mem_req)
		else $error("init ran past end");
	a_scrub_gap: assert property (ack && !mem_we |=> !mem_req [*8])
		else $error("scrub too soon");
	cover property (ack && mem_we && mem_line == mem_last_line);
	cover property (ack && !mem_we);
	cover property (host_to_hub);
endmodule // dsfh_scrub_checker
bind dsfh_scrub dsfh_scrub_checker u_chk (.core_clk, .rst_n, .reg_rd, .reg_rdata,
	.mem_last_line, .mem_req, .mem_we, .mem_line, .mem_ack, .host_addr, .host_valid,
	.host_to_hub, .host_to_dram);

// >>> dsfh_dram.sv
// Behavioural DRAM engine answering line requests
`timescale 1ns/1ps
module dsfh_dram (
	// Clock, reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Requests, test controls
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic slow,
	input wire logic [1:0] err,
	// Answers
	output logic mem_ack,
	output logic mem_rsp,
	output logic mem_corr,
	output logic mem_uncorr,
	output int n_wr
);
	logic [1:0] cnt;
	// Never two acks running, so a dropped request gets no stray ack
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			{mem_ack, mem_rsp, mem_corr, mem_uncorr, cnt} <= '0;
			n_wr <= 0;
		end else begin
			cnt <= cnt + 2'h1;
			mem_ack <= mem_req && !mem_ack && (!slow || cnt == 2'h3);
			mem_rsp <= mem_ack && !mem_we;
			{mem_uncorr, mem_corr} <= (mem_ack && !mem_we) ? err : 2'h0;
			n_wr <= n_wr + int'(mem_ack && mem_we);
		end
	end
endmodule // dsfh_dram

// >>> dsfh_scrub_test.sv
// Self-checking testbench of the scrub and hole block
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
	$display("ERROR %0t got %0h", $time, a); end end
module dsfh_scrub_test;
	logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, host_valid = 0, slow = 0;
	logic mem_req, mem_we, mem_ack, mem_rsp, mem_corr, mem_uncorr, irq;
	logic host_to_hub, host_to_dram;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
	logic [27:0] mem_line;
	logic [1:0] err = 2'h0;
	logic [33:0] host_addr = 34'h0;
	int err_total = 0, n_tests = 0, n_wr, i;
	dsfh_scrub dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.mem_last_line(28'hF), .mem_req, .mem_we, .mem_line, .mem_ack, .mem_rsp,
		.mem_corr, .mem_uncorr, .host_addr, .host_valid, .host_to_hub, .host_to_dram, .irq);
	dsfh_dram mdl (.core_clk, .rst_n, .mem_req, .mem_we, .slow, .err, .mem_ack, .mem_rsp,
		.mem_corr, .mem_uncorr, .n_wr);
	initial forever #5 core_clk = ~core_clk;
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge core_clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic host(input logic [33:0] a, input logic [1:0] e);
		@(posedge core_clk);
		{host_addr, host_valid} <= {a, 1'b1};
		#1 `CHK({host_to_hub, host_to_dram}, e)
	endtask
	task complete_run;
		$display("compares %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#400000 err_total++;
		complete_run;
	end
	initial begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(8'h52); `CHK(d, 16'h0000)
		rd(8'h58); `CHK(d, 16'h0000)
		rd(8'h10); `CHK(d, 16'h0000)
		$display("reset test done");
		wr(8'h58, 16'h0080);
		rd(8'h58); `CHK(d, 16'h0080)
		host(34'h00F00000, 2'b10);
		host(34'h00FFFFFF, 2'b10);
		host(34'h01000000, 2'b01);
		host(34'h00EFFFFF, 2'b01);
		wr(8'h58, 16'h0000);
		host(34'h00F00000, 2'b01);
		host_valid <= 1'b0;
		$display("hole test done");
		wr(8'h71, 16'h0007);
		wr(8'h52, 16'h0001);
		for (i = 0; i < 100 && d[3] !== 1'b1; i++) rd(8'h52);
		`CHK(d, 16'h0009)
		`CHK(n_wr, 16)
		`CHK(irq, 1'b1)
		rd(8'h70); `CHK(d, 16'h0001)
		$display("init test done");
		{slow, err} <= 3'b101;
		wr(8'h52, 16'h0005);
		for (i = 0; i < 33000 && mem_req !== 1'b1; i++) @(posedge core_clk) #1;
		`CHK(i >= 31990 && i <= 32010, 1'b1)
		`CHK(mem_we, 1'b0)
		repeat (20) @(posedge core_clk);
		rd(8'h70); `CHK(d, 16'h0002)
		`CHK(mem_line, 28'h0)
		wr(8'h52, 16'h0004);
		$display("scrub test done");
		complete_run;
	end
endmodule // dsfh_scrub_test
